// >>> src/ebp_bridge_pwm.v
// Enhanced bridge PWM output stage with APB register access.
`timescale 1ns/100ps
// Register map, one aligned 32-bit word each, with only the low bits used.
//   0x000 duty low byte: the eight upper duty bits, buffered.
//   0x004 unit control: [7:6] output configuration, [5:4] duty low bits.
//         [3:2] select PWM when both are set, [1:0] give output polarity.
//   0x008 active duty buffer: read-only copy used by the comparator.
//   0x00C period register: last timer value of a PWM period.
//   0x010 timer control: [2] runs the timer, [1:0] select the prescale.
//   0x014 dead-band count: seven-bit delay in instruction cycles.
//   0x018 period timer: read-only live count.
//   0x01C status: pending direction, active direction, active
//         configuration and latched duty low bits, all read-only.
//
// Timing chain.
//   Each clock edge is one oscillator period.
//   A two-bit sub-cycle counter forms the instruction cycle.
//   A four-bit prescaler divides that by 1, 4 or 16.
//   Its wrap advances the period timer by one tick.
//   The comparator sees the timer with two extra low bits.
//   The duty resolution is therefore one oscillator period times the prescale.
//   A full period lasts the period value plus one, times four, times the prescale.
//
// Hazards worth knowing.
//   Configuration, polarity and direction change only at a period boundary.
//   A write therefore never glitches a pin in the middle of a cycle.
//   The first boundary after reset is the first time any setting reaches the pins.
//   A direction change swaps the steady pair one timer tick early.
//   The modulated pair stays off for that tick, so the old leg can turn off.
//   Software should still lower the duty for a period when it is near full scale.
//   Changing polarity while the pins drive a bridge is unsafe.
//   Both pairs flip at the next boundary and no interlock guards that.
//   Dead-band is quantised to instruction cycles.
//   It applies in the half-bridge configuration only.
//   The full-bridge modes rely on the early swap instead.
//   Stopping the timer freezes every counter, so the pins hold their level.
//   Leaving PWM mode clears the raw level but keeps the active settings.
//   The bus has no wait states and flags unmapped words with an error.
`include "ebp_defines.vh"

module ebp_bridge_pwm (
  input  wire        clk_in,
  input  wire        rst_n_in,
  input  wire        psel_in,
  input  wire        penable_in,
  input  wire        pwrite_in,
  input  wire [11:0] paddr_in,
  input  wire [31:0] pwdata_in,
  output reg  [31:0] prdata_out,
  output wire        pready_out,
  output wire        pslverr_out,
  output reg         bridge_out_a_out,
  output reg         bridge_out_b_out,
  output reg         bridge_out_c_out,
  output reg         bridge_out_d_out
);

  // Software-visible registers.
  reg  [7:0] duty_low_byte_r;
  reg  [7:0] unit_control_reg_r;
  reg  [7:0] active_duty_buffer_r;
  reg  [7:0] period_register_r;
  reg  [2:0] timer_control_reg_r;
  reg  [6:0] deadband_count_r;
  // Timing state.
  reg  [7:0] period_timer_r;
  reg  [1:0] sub_cnt_r;
  reg  [3:0] pre_cnt_r;
  reg  [1:0] duty_lsb_latch_r;
  reg        pwm_raw_r;
  reg  [1:0] cfg_act_r;
  reg  [1:0] pol_act_r;
  reg        dir_rev_r;
  reg        dir_pend_r;
  reg  [6:0] db_a_cnt_r;
  reg  [6:0] db_b_cnt_r;
  reg        out_a_act_r;
  reg        out_b_act_r;

  wire       pwm_mode;
  wire       timer_on;
  wire [1:0] ps_sel;
  wire [3:0] pre_top;
  wire       osc_tick;
  wire       tcy_tick;
  wire       timer_tick;
  wire       period_match;
  wire       boundary;
  wire [9:0] ext_timer;
  wire [9:0] duty_act;
  wire       early_switch;
  wire       req_dir_rev;
  wire       full_mode;
  wire       pwm_live;
  wire       wr_en;
  wire       rd_en;
  wire       addr_hit;

  // Register fields; only the 11 mode code enables PWM operation.
  assign pwm_mode  = unit_control_reg_r[`EBP_UC_MODE_HI:`EBP_UC_MODE_LO] == `EBP_UC_PWM_MODE;
  assign timer_on  = timer_control_reg_r[`EBP_TC_ON_BIT];
  assign ps_sel    = timer_control_reg_r[`EBP_TC_PS_HI:`EBP_TC_PS_LO];
  assign req_dir_rev = unit_control_reg_r[`EBP_UC_DIR_BIT];
  assign full_mode = cfg_act_r[0];

  // The prescale compare value is the last count of the prescaler.
  // The prescaler therefore wraps after 1, 4 or 16 instruction cycles.
  // Prescale 1, 4 or 16 instruction cycles; codes 2 and 3 both give 16.
  assign pre_top = (ps_sel == 2'h0) ? 4'h0 : (ps_sel == 2'h1) ? 4'h3 : 4'hF;

  // Every clk edge is one oscillator period; the sub-cycle counter forms Q clocks.
  // Stopping the timer freezes all of these, so the pins hold their level.
  assign osc_tick   = timer_on;
  assign tcy_tick   = osc_tick && (sub_cnt_r == 2'h3);
  assign timer_tick = tcy_tick && (pre_cnt_r == pre_top);
  assign period_match = period_timer_r == period_register_r;
  assign boundary   = timer_tick && period_match;

  // Timer extended by two sub-cycle bits: Q clock at prescale 1, prescaler bits otherwise.
  // The two extra bits must step once per prescaled oscillator period.
  // At prescale 16 the upper prescaler bits are used, since the lower ones
  // would wrap four times per timer tick and end the duty in the wrong place.
  assign ext_timer = (ps_sel == 2'h0) ? {period_timer_r, sub_cnt_r} :
                     (ps_sel == 2'h1) ? {period_timer_r, pre_cnt_r[1:0]} :
                     {period_timer_r, pre_cnt_r[3:2]};
  assign duty_act  = {active_duty_buffer_r, duty_lsb_latch_r};

  // Live PWM level: the raw flop drops only at the edge after the match.
  // The match cycle itself is masked here, so exactly the duty is high.
  // A duty beyond the period never matches and leaves the level set.
  assign pwm_live = pwm_raw_r && !(osc_tick && ext_timer == duty_act);

  // Early window: the last timer tick of the period.
  // Its length is one timer tick, so it follows the prescale by itself.
  // Outside a pending change the window has no effect on the pins.
  assign early_switch = period_match && dir_pend_r;

  // Oscillator divider and period timer.
  // The timer only advances on a prescaled tick; at the match it wraps to
  // zero, which is the period boundary seen by every other process.
  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sub_cnt_r      <= 2'h0;
      pre_cnt_r      <= 4'h0;
      period_timer_r <= 8'h00;
    end else if (osc_tick) begin
      sub_cnt_r <= sub_cnt_r + 2'h1;
      if (tcy_tick) begin
        pre_cnt_r <= (pre_cnt_r == pre_top) ? 4'h0 : pre_cnt_r + 4'h1;
        if (timer_tick) begin
          period_timer_r <= period_match ? 8'h00 : period_timer_r + 8'h01;
        end
      end
    end
  end

  // Raw PWM, duty buffering and per-cycle configuration loading.
  // Loading everything at the boundary is the double buffer: writes land in
  // the software registers and reach the pins only with the next period.
  // Leaving PWM mode drops the raw level at once.
  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      active_duty_buffer_r <= `EBP_RST_BYTE;
      duty_lsb_latch_r     <= 2'h0;
      pwm_raw_r            <= 1'b0;
      cfg_act_r            <= `EBP_CFG_SINGLE;
      pol_act_r            <= 2'h0;
      dir_rev_r            <= 1'b0;
    end else if (!pwm_mode) begin
      pwm_raw_r <= 1'b0;
    end else if (boundary) begin
      // Duty zero never sets the output for the new period.
      active_duty_buffer_r <= duty_low_byte_r;
      duty_lsb_latch_r     <= unit_control_reg_r[`EBP_UC_DLSB_HI:`EBP_UC_DLSB_LO];
      pwm_raw_r <= {duty_low_byte_r,
                    unit_control_reg_r[`EBP_UC_DLSB_HI:`EBP_UC_DLSB_LO]} != 10'h000;
      cfg_act_r <= unit_control_reg_r[`EBP_UC_CFG_HI:`EBP_UC_CFG_LO];
      pol_act_r <= unit_control_reg_r[`EBP_UC_POL_HI:`EBP_UC_POL_LO];
      dir_rev_r <= req_dir_rev;
    end else if (osc_tick && ext_timer == duty_act) begin
      // A duty beyond the period never matches, so the output stays set.
      pwm_raw_r <= 1'b0;
    end
  end

  // Pending direction change; the bit may be written any time in the cycle.
  // The flag compares the written configuration with the one in use, so it
  // falls by itself once the boundary has loaded the new direction.
  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      dir_pend_r <= 1'b0;
    end else begin
      dir_pend_r <= pwm_mode && full_mode &&
                    unit_control_reg_r[`EBP_UC_CFG_HI:`EBP_UC_CFG_LO] != cfg_act_r &&
                    unit_control_reg_r[`EBP_UC_CFG_LO];
    end
  end

  // Half-bridge dead-band: each active-going edge restarts its counter.
  // Counting runs on instruction-cycle ticks, so the delay is quantised to 4 clocks.
  // It follows the live level one clock late, so with no delay A is the single-output
  // waveform delayed by one clock and B is its exact complement.
  // A long delay keeps an output low for the whole cycle; no error is flagged.
  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      db_a_cnt_r  <= 7'h00;
      db_b_cnt_r  <= 7'h00;
      out_a_act_r <= 1'b0;
      out_b_act_r <= 1'b0;
    end else if (!pwm_live) begin
      // A off at once; B goes active after its own delay.
      out_a_act_r <= 1'b0;
      db_a_cnt_r  <= 7'h00;
      if (!out_b_act_r) begin
        if (db_b_cnt_r >= deadband_count_r) begin
          out_b_act_r <= 1'b1;
        end else if (tcy_tick) begin
          db_b_cnt_r <= db_b_cnt_r + 7'h01;
        end
      end
    end else begin
      // If duty ends before the delay expires, A never goes active.
      out_b_act_r <= 1'b0;
      db_b_cnt_r  <= 7'h00;
      if (!out_a_act_r) begin
        if (db_a_cnt_r >= deadband_count_r) begin
          out_a_act_r <= 1'b1;
        end else if (tcy_tick) begin
          db_a_cnt_r <= db_a_cnt_r + 7'h01;
        end
      end
    end
  end

  // Output steering per configuration, then polarity per pair.
  // The case decodes only the active configuration; the written one acts only
  // through the early window, so a mode change in mid-period cannot produce a partial pattern.
  reg a_nxt;
  reg b_nxt;
  reg c_nxt;
  reg d_nxt;
  always @* begin
    a_nxt = 1'b0;
    b_nxt = 1'b0;
    c_nxt = 1'b0;
    d_nxt = 1'b0;
    if (pwm_mode) begin
      case (cfg_act_r)
        `EBP_CFG_SINGLE: begin
          a_nxt = pwm_live;
        end
        `EBP_CFG_HALF: begin
          a_nxt = out_a_act_r;
          b_nxt = out_b_act_r;
        end
        `EBP_CFG_FULL_FWD,
        `EBP_CFG_FULL_REV: begin
          // Raw PWM without dead-band; one steady and one modulated output.
          // The steady pair takes the new direction now; B and D stay off
          // until the boundary, which gives the old leg a tick to turn off.
          if (early_switch) begin
            a_nxt = dir_rev_r;
            c_nxt = !dir_rev_r;
          end else if (dir_rev_r) begin
            c_nxt = 1'b1;
            b_nxt = pwm_live;
          end else begin
            a_nxt = 1'b1;
            d_nxt = pwm_live;
          end
        end
        default: begin
          a_nxt = 1'b0;
        end
      endcase
    end
  end

  // Registered pins; a set polarity bit makes that pair active-low.
  // The pin flops remove any decode glitch from the steering logic.
  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      bridge_out_a_out <= 1'b0;
      bridge_out_b_out <= 1'b0;
      bridge_out_c_out <= 1'b0;
      bridge_out_d_out <= 1'b0;
    end else begin
      bridge_out_a_out <= a_nxt ^ pol_act_r[1];
      bridge_out_c_out <= c_nxt ^ pol_act_r[1];
      bridge_out_b_out <= b_nxt ^ pol_act_r[0];
      bridge_out_d_out <= d_nxt ^ pol_act_r[0];
    end
  end

  // APB slave: zero wait states, unmapped addresses answer with an error.
  // Read data is taken in the setup cycle so that it already stands when the
  // access phase completes; the bus never needs a wait state.
  assign wr_en = psel_in && penable_in && pwrite_in;
  assign rd_en = psel_in && !penable_in && !pwrite_in;
  assign addr_hit = (paddr_in[11:5] == 7'h00) && (paddr_in[1:0] == 2'h0);
  assign pready_out  = 1'b1;
  assign pslverr_out = psel_in && penable_in && !addr_hit;

  // Register writes.
  // Writes to read-only words are dropped without an error response.
  // The duty and direction bits may change at any point of a period.
  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      duty_low_byte_r     <= `EBP_RST_BYTE;
      unit_control_reg_r  <= `EBP_RST_BYTE;
      period_register_r   <= `EBP_RST_PERIOD;
      timer_control_reg_r <= 3'h0;
      deadband_count_r    <= 7'h00;
    end else if (wr_en && addr_hit) begin
      case (paddr_in)
        `EBP_OFF_DUTY_LOW:   duty_low_byte_r     <= pwdata_in[7:0];
        `EBP_OFF_UNIT_CTRL:  unit_control_reg_r  <= pwdata_in[7:0];
        `EBP_OFF_PERIOD:     period_register_r   <= pwdata_in[7:0];
        `EBP_OFF_TIMER_CTRL: timer_control_reg_r <= pwdata_in[2:0];
        `EBP_OFF_DEADBAND:   deadband_count_r    <= pwdata_in[6:0];
        default:             duty_low_byte_r     <= duty_low_byte_r;
      endcase
    end
  end

  // Read data is captured in the setup cycle; the active duty buffer is read-only.
  // Unused upper bits read as zero.
  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      prdata_out <= 32'h0000_0000;
    end else if (rd_en) begin
      case (paddr_in)
        `EBP_OFF_DUTY_LOW:    prdata_out <= {24'h000000, duty_low_byte_r};
        `EBP_OFF_UNIT_CTRL:   prdata_out <= {24'h000000, unit_control_reg_r};
        `EBP_OFF_ACTIVE_DUTY: prdata_out <= {24'h000000, active_duty_buffer_r};
        `EBP_OFF_PERIOD:      prdata_out <= {24'h000000, period_register_r};
        `EBP_OFF_TIMER_CTRL:  prdata_out <= {29'h00000000, timer_control_reg_r};
        `EBP_OFF_DEADBAND:    prdata_out <= {25'h0000000, deadband_count_r};
        `EBP_OFF_TIMER:       prdata_out <= {24'h000000, period_timer_r};
        `EBP_OFF_STATUS:      prdata_out <= {26'h0000000, dir_pend_r, dir_rev_r,
                                             cfg_act_r, duty_lsb_latch_r};
        default:              prdata_out <= 32'h0000_0000;
      endcase
    end
  end

endmodule

// >>> src/ebp_defines.vh
// Register offsets, field positions, reset values and timing counts for the bridge PWM block.
`ifndef EBP_DEFINES_VH
`define EBP_DEFINES_VH

// Register byte offsets on the APB.
`define EBP_OFF_DUTY_LOW     12'h000
`define EBP_OFF_UNIT_CTRL    12'h004
`define EBP_OFF_ACTIVE_DUTY  12'h008
`define EBP_OFF_PERIOD       12'h00C
`define EBP_OFF_TIMER_CTRL   12'h010
`define EBP_OFF_DEADBAND     12'h014
`define EBP_OFF_TIMER        12'h018
`define EBP_OFF_STATUS       12'h01C

// Unit control register fields.
`define EBP_UC_CFG_HI        7
`define EBP_UC_CFG_LO        6
`define EBP_UC_DIR_BIT       7
`define EBP_UC_DLSB_HI       5
`define EBP_UC_DLSB_LO       4
`define EBP_UC_MODE_HI       3
`define EBP_UC_MODE_LO       2
`define EBP_UC_POL_HI        1
`define EBP_UC_POL_LO        0
`define EBP_UC_PWM_MODE      2'h3

// Timer control register fields.
`define EBP_TC_ON_BIT        2
`define EBP_TC_PS_HI         1
`define EBP_TC_PS_LO         0

// Output configuration codes.
`define EBP_CFG_SINGLE       2'h0
`define EBP_CFG_FULL_FWD     2'h1
`define EBP_CFG_HALF         2'h2
`define EBP_CFG_FULL_REV     2'h3

// Reset values.
`define EBP_RST_BYTE         8'h00
`define EBP_RST_PERIOD       8'hFF

// Oscillator periods per instruction cycle.
`define EBP_TOSC_PER_TCY     4

`endif

// >>> verification/ebp_checker.sv
// Port-level assertions for the bridge PWM block.
`timescale 1ns/100ps
`include "ebp_defines.vh"
module ebp_checker (
  input wire        clk_in,
  input wire        rst_n_in,
  input wire        psel_in,
  input wire        penable_in,
  input wire        pwrite_in,
  input wire [11:0] paddr_in,
  input wire [31:0] pwdata_in,
  input wire [31:0] prdata_out,
  input wire        pslverr_out,
  input wire        bridge_out_a_out,
  input wire        bridge_out_b_out,
  input wire        bridge_out_c_out,
  input wire        bridge_out_d_out
);
  wire       wr = psel_in && penable_in && pwrite_in;
  wire       ucw = wr && paddr_in == `EBP_OFF_UNIT_CTRL;
  wire       tcw = wr && paddr_in == `EBP_OFF_TIMER_CTRL;
  reg  [7:0] uc_r;
  reg        on_r;
  reg  [8:0] stl_r;
  reg  [8:0] fl_r;
  // Pins seen in their active sense, so the checks hold for either polarity.
  wire       a = bridge_out_a_out ^ uc_r[1];
  wire       b = bridge_out_b_out ^ uc_r[0];
  wire       c = bridge_out_c_out ^ uc_r[1];
  wire       d = bridge_out_d_out ^ uc_r[0];
  wire       pwm = on_r && uc_r[3:2] == 2'h3;
  wire       ok = pwm && stl_r == 9'h12C;
  wire       fok = pwm && uc_r[6] && fl_r == 9'h12C;
  // Settling counters outlast the longest period the bench uses, since setup loads only at a boundary.
  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      uc_r <= 8'h00;
      on_r <= 1'b0;
      stl_r <= 9'h000;
      fl_r <= 9'h000;
    end else begin
      if (ucw)
        uc_r <= pwdata_in[7:0];
      if (tcw)
        on_r <= pwdata_in[2];
      if (ucw || tcw)
        stl_r <= 9'h000;
      else if (stl_r != 9'h12C)
        stl_r <= stl_r + 9'h001;
      if (ucw && (!pwdata_in[6] || pwdata_in[1:0] != uc_r[1:0]))
        fl_r <= 9'h000;
      else if (fl_r != 9'h12C)
        fl_r <= fl_r + 9'h001;
    end
  end
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!rst_n_in);
  sequence s_bd_off;
    (!b && !d) [*3];
  endsequence
  a_reset_quiet: assert property ($rose(rst_n_in) |-> !(a || b || c || d))
    else $error("Bridge pin active after reset");
  a_two_max: assert property (ok |-> $countones({a, b, c, d}) <= 2)
    else $error("More than two bridge pins active");
  a_single_pins: assert property (ok && uc_r[7:6] == 2'h0 |-> !(b || c || d))
    else $error("Single mode drives extra pins");
  a_fwd_pins: assert property (ok && uc_r[7:6] == 2'h1 |-> a && !b && !c)
    else $error("Forward pin pattern wrong");
  a_rev_pins: assert property (ok && uc_r[7:6] == 2'h3 |-> c && !a && !d)
    else $error("Reverse pin pattern wrong");
  a_half_excl: assert property (ok && uc_r[7:6] == 2'h2 |-> !(a && b) && !(c || d))
    else $error("Half bridge overlap");
  a_swap_to_rev: assert property (fok && $fell(a) |-> c ##0 s_bd_off)
    else $error("Forward to reverse swap wrong");
  a_swap_to_fwd: assert property (fok && $fell(c) |-> a ##0 s_bd_off)
    else $error("Reverse to forward swap wrong");
  a_err_map: assert property (pslverr_out == (psel_in && penable_in &&
    (paddr_in > `EBP_OFF_STATUS || paddr_in[1:0] != 2'h0)))
    else $error("Slave error on wrong access");
  a_read_hold: assert property (!(psel_in && !penable_in && !pwrite_in) |=> $stable(prdata_out))
    else $error("Read data changed outside setup");
endmodule
bind ebp_bridge_pwm ebp_checker u_chk (
  .clk_in, .rst_n_in, .psel_in, .penable_in, .pwrite_in, .paddr_in, .pwdata_in,
  .prdata_out, .pslverr_out, .bridge_out_a_out, .bridge_out_b_out,
  .bridge_out_c_out, .bridge_out_d_out
);

// >>> verification/ebp_switch_model.sv
// Bridge switch driver model that counts leg shorts.
`timescale 1ns/100ps
module ebp_switch_model (
  input  wire        clk_in,
  input  wire        rst_n_in,
  input  wire [3:0]  gate_in,
  output reg  [15:0] short_cnt_out
);
  reg  [3:0] g1_r;
  reg  [3:0] g2_r;
  wire [3:0] on = gate_in | g1_r | g2_r;
  // Switches turn off two cycles late, so a leg shorts unless turn-on waits.
  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      g1_r <= 4'h0;
      g2_r <= 4'h0;
      short_cnt_out <= 16'h0000;
    end else begin
      g1_r <= gate_in;
      g2_r <= g1_r;
      if ((on[0] && on[1]) || (on[2] && on[3]))
        short_cnt_out <= short_cnt_out + 16'h0001;
    end
  end
endmodule

// >>> verification/tb_top.sv
// Self-checking bench for the bridge PWM block.
`timescale 1ns/100ps
`include "ebp_defines.vh"
module tb_top;
  reg         clk_in;
  reg         rst_n_in;
  reg         psel_in;
  reg         penable_in;
  reg         pwrite_in;
  reg  [11:0] paddr_in;
  reg  [31:0] pwdata_in;
  wire [31:0] prdata_out;
  wire        pready_out;
  wire        pslverr_out;
  wire        a, b, c, d;
  wire [15:0] shorts;
  reg  [31:0] q;
  reg         e;
  reg  [15:0] sh0;
  integer     num_errors, num_checks, n_sw;
  ebp_bridge_pwm dut (
    .clk_in(clk_in), .rst_n_in(rst_n_in), .psel_in(psel_in), .penable_in(penable_in),
    .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in),
    .prdata_out(prdata_out), .pready_out(pready_out), .pslverr_out(pslverr_out),
    .bridge_out_a_out(a), .bridge_out_b_out(b), .bridge_out_c_out(c), .bridge_out_d_out(d)
  );
  ebp_switch_model sw (
    .clk_in(clk_in), .rst_n_in(rst_n_in), .gate_in({d, c, b, a}), .short_cnt_out(shorts)
  );
  task chk(input [31:0] s, input [31:0] x);
    begin
      num_checks = num_checks + 1;
      if (s !== x) begin
        num_errors = num_errors + 1;
        $display("Error at %0t: seen %h expected %h", $time, s, x);
      end
    end
  endtask
  // Request is held until pready is sampled high; data is taken at that edge.
  task apb(input [11:0] ad, input w, input [31:0] wd);
    begin
      @(posedge clk_in);
      psel_in <= 1'b1;
      penable_in <= 1'b0;
      pwrite_in <= w;
      paddr_in <= ad;
      pwdata_in <= wd;
      @(posedge clk_in);
      penable_in <= 1'b1;
      @(posedge clk_in);
      while (pready_out !== 1'b1) @(posedge clk_in);
      q = prdata_out;
      e = pslverr_out;
      psel_in <= 1'b0;
      penable_in <= 1'b0;
    end
  endtask
  // Any window of one full period holds the same high-time on each pin.
  task run(input [1:0] cf, input [9:0] du, input [1:0] pl, input [6:0] db,
           input [1:0] ps, input [8:0] ea, eb, ec, ed);
    integer    n, na, nb, nc, nd;
    reg [15:0] s0;
    begin
      n = 16 << (2 * ps);
      apb(`EBP_OFF_DUTY_LOW, 1'b1, {24'h0, du[9:2]});
      apb(`EBP_OFF_UNIT_CTRL, 1'b1, {24'h0, cf, du[1:0], 2'h3, pl});
      apb(`EBP_OFF_DEADBAND, 1'b1, {25'h0, db});
      apb(`EBP_OFF_TIMER_CTRL, 1'b1, {29'h0, 1'b1, ps});
      repeat (8 * n + 320) @(posedge clk_in);
      s0 = shorts;
      {na, nb, nc, nd} = 128'h0;
      repeat (n) begin
        @(posedge clk_in);
        na = na + a;
        nb = nb + b;
        nc = nc + c;
        nd = nd + d;
      end
      chk(na, {23'h0, ea});
      chk(nb, {23'h0, eb});
      chk(nc, {23'h0, ec});
      chk(nd, {23'h0, ed});
      if (db != 7'h00)
        chk({16'h0, shorts - s0}, 32'h0);
    end
  endtask
  task end_of_test;
    begin
      $display("Checks %0d errors %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0)
        $display("STATUS OK");
      else
        $display("STATUS NOT OK");
      $finish;
    end
  endtask
  initial begin
    clk_in = 1'b0;
    forever #10 clk_in = ~clk_in;
  end
  // A hang is cut short well after the expected run length.
  initial begin
    #400000;
    num_errors = num_errors + 1;
    end_of_test;
  end
  initial begin
    {num_errors, num_checks} = 64'h0;
    {rst_n_in, psel_in, penable_in, pwrite_in, paddr_in, pwdata_in} = 48'h0;
    repeat (4) @(posedge clk_in);
    rst_n_in <= 1'b1;
    apb(`EBP_OFF_PERIOD, 1'b0, 32'h0);
    chk(q, 32'h000000FF);
    apb(12'h020, 1'b0, 32'h0);
    chk({31'h0, e}, 32'h1);
    apb(`EBP_OFF_PERIOD, 1'b1, 32'h3);
    run(2'h0, 10'h008, 2'h0, 7'h00, 2'h0, 9'h008, 9'h000, 9'h000, 9'h000);
    run(2'h0, 10'h3FF, 2'h0, 7'h00, 2'h0, 9'h010, 9'h000, 9'h000, 9'h000);
    run(2'h0, 10'h008, 2'h0, 7'h00, 2'h1, 9'h020, 9'h000, 9'h000, 9'h000);
    run(2'h2, 10'h008, 2'h0, 7'h00, 2'h0, 9'h008, 9'h008, 9'h000, 9'h000);
    run(2'h2, 10'h008, 2'h0, 7'h01, 2'h0, 9'h004, 9'h004, 9'h000, 9'h000);
    run(2'h2, 10'h008, 2'h0, 7'h7F, 2'h0, 9'h000, 9'h000, 9'h000, 9'h000);
    run(2'h1, 10'h006, 2'h3, 7'h00, 2'h0, 9'h000, 9'h010, 9'h010, 9'h00A);
    run(2'h1, 10'h006, 2'h0, 7'h00, 2'h0, 9'h010, 9'h000, 9'h000, 9'h006);
    run(2'h3, 10'h006, 2'h0, 7'h00, 2'h0, 9'h000, 9'h006, 9'h010, 9'h000);
    run(2'h1, 10'h008, 2'h0, 7'h05, 2'h2, 9'h100, 9'h000, 9'h000, 9'h080);
    // Write just after mid-period so the boundary is far away.
    @(negedge d);
    apb(`EBP_OFF_DUTY_LOW, 1'b1, 32'h5A);
    apb(`EBP_OFF_ACTIVE_DUTY, 1'b1, 32'h33);
    apb(`EBP_OFF_ACTIVE_DUTY, 1'b0, 32'h0);
    chk(q, 32'h02);
    repeat (300) @(posedge clk_in);
    apb(`EBP_OFF_ACTIVE_DUTY, 1'b0, 32'h0);
    chk(q, 32'h5A);
    // Forward at prescale 4 with a short duty, then reverse well before the boundary.
    run(2'h1, 10'h002, 2'h0, 7'h00, 2'h1, 9'h040, 9'h000, 9'h000, 9'h008);
    @(negedge d);
    sh0 = shorts;
    apb(`EBP_OFF_UNIT_CTRL, 1'b1, 32'hEC);
    @(negedge clk_in);
    chk({31'h0, a}, 32'h1);
    @(posedge c);
    @(negedge clk_in);
    chk({31'h0, a}, 32'h0);
    n_sw = 0;
    while (b !== 1'b1) begin
      @(negedge clk_in);
      n_sw = n_sw + 1;
    end
    chk(n_sw, 32'h10);
    repeat (4) @(posedge clk_in);
    chk({16'h0, shorts - sh0}, 32'h0);
    end_of_test;
  end
endmodule
